// *** ldf_core.sv ***
/*
 * Eight-channel low-side driver digital core: serial shift register,
 * data/control/fault banks, fault deglitch and shared alert.
 * Assumes analog comparators and a special-command decoder outside,
 * the decoder on mclk_in and the pins and comparators asynchronous.
 */
`timescale 1ns/1ps
`include "ldf_params.svh"

module ldf_core #(
  parameter bit OPEN_LOAD_DETECT = 1'b1
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic latch_in,
  input wire logic serial_data_in,
  input wire logic chip_reset_n_in,
  input wire logic [7:0] overcurrent_in,
  input wire logic [7:0] open_load_sense_in,
  input wire logic thermal_shutdown_in,
  input wire logic supply_undervoltage_lockout_in,
  input wire ldf_pkg::ldf_cmd_t special_cmd_in,
  output logic serial_data_out,
  output logic fault_alert_n_out,
  output logic fault_alert_n_oe_out,
  output logic [7:0] channel_on_out,
  output logic [7:0] ctrl_reg_out,
  output logic pwm_start_out
);

  // Pin filters
  logic [3:0] pin_raw;
  logic [3:0] pin_f;
  assign pin_raw = {chip_reset_n_in, serial_data_in, latch_in, sclk_in};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_pin
      ldf_filt u_filt (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .raw_in(pin_raw[gp]),
        .clean_out(pin_f[gp])
      );
    end
  endgenerate

  logic sclk_f;
  logic latch_f;
  logic sdat_f;
  logic rst_pin_n_f;
  assign {rst_pin_n_f, sdat_f, latch_f, sclk_f} = pin_f;

  // Comparator synchronisers: first stage read only by second
  logic [17:0] ana_s1_q;
  logic [17:0] ana_s2_q;
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ana_s1_q <= '0;
      ana_s2_q <= '0;
    end
    else
    begin
      ana_s1_q <= {supply_undervoltage_lockout_in, thermal_shutdown_in,
                   open_load_sense_in, overcurrent_in};
      ana_s2_q <= ana_s1_q;
    end
  end

  logic uv_s;
  logic tsd_s;
  logic [7:0] ol_s;
  logic [7:0] oc_s;
  assign {uv_s, tsd_s, ol_s, oc_s} = ana_s2_q;

  // Undervoltage acts as a full logic reset and clears the alert enable
  logic lrst;
  assign lrst = uv_s | ~rst_pin_n_f;

  // Serial link state
  logic sclk_prev_q;
  logic latch_prev_q;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic dout_q;
  logic dout_d;
  logic wr_ctrl_pend_q;
  logic wr_ctrl_pend_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic pwm_q;
  logic pwm_d;
  logic commit;
  logic frst;
  ldf_pkg::ldf_fault_t fault_q;
  ldf_pkg::ldf_fault_t fault_d;

  logic sclk_rise;
  logic sclk_fall;
  logic latch_rise;
  logic latch_fall;
  assign sclk_rise = sclk_f & ~sclk_prev_q;
  assign sclk_fall = ~sclk_f & sclk_prev_q;
  assign latch_rise = latch_f & ~latch_prev_q;
  assign latch_fall = ~latch_f & latch_prev_q;

  always_comb
  begin
    sr_d = sr_q;
    dout_d = dout_q;
    wr_ctrl_pend_d = wr_ctrl_pend_q;
    rd_pend_d = rd_pend_q;
    data_d = data_q;
    ctrl_d = ctrl_q;
    pwm_d = 1'b0;
    commit = 1'b0;
    frst = 1'b0;
    if (special_cmd_in.valid)
    begin
      unique case (special_cmd_in.code)
        ldf_pkg::LDF_CMD_WR_CTRL: wr_ctrl_pend_d = 1'b1;
        ldf_pkg::LDF_CMD_RD_CTRL:
        begin
          sr_d = {ctrl_q, 8'h00};
          dout_d = ctrl_q[7];
          rd_pend_d = 1'b1;
        end
        ldf_pkg::LDF_CMD_RD_DATA:
        begin
          sr_d = {data_q, 8'h00};
          dout_d = data_q[7];
          rd_pend_d = 1'b1;
        end
        ldf_pkg::LDF_CMD_FAULT_RST: frst = 1'b1;
        ldf_pkg::LDF_CMD_PWM_START: pwm_d = 1'b1;
        default: pwm_d = 1'b0;
      endcase
    end
    else if (latch_fall)
    begin
      // A pending register read keeps its copy for this one frame
      rd_pend_d = 1'b0;
      if (!rd_pend_q)
      begin
        // Fresh fault snapshot at frame start, read while writing
        sr_d = fault_q;
        dout_d = fault_q.open_load_bits[7];
      end
    end
    else if (latch_rise)
    begin
      commit = ~wr_ctrl_pend_q;
      if (wr_ctrl_pend_q)
        ctrl_d = sr_q[7:0];
      else
        data_d = sr_q[7:0];
      wr_ctrl_pend_d = 1'b0;
    end
    else if (sclk_rise && !latch_f)
      sr_d = {sr_q[14:0], sdat_f};
    else if (sclk_fall && !latch_f)
      dout_d = sr_q[15];
  end

  // Fault deglitch per channel
  logic [7:0] oc_set;
  logic [7:0] ol_set;
  genvar gc;
  generate
    for (gc = 0; gc < `LDF_CHANNELS; gc++)
    begin : g_ch
      logic [`LDF_OCP_CNT_W-1:0] oc_cnt_q;
      logic [`LDF_OCP_CNT_W-1:0] oc_cnt_d;
      logic [`LDF_OL_CNT_W-1:0] ol_cnt_q;
      logic [`LDF_OL_CNT_W-1:0] ol_cnt_d;
      logic oc_act;
      logic ol_act;
      assign oc_act = oc_s[gc] & channel_on_out[gc];
      // Sensing only while driven off, on the detecting variant
      assign ol_act = OPEN_LOAD_DETECT & ol_s[gc] & ~data_q[gc];
      always_comb
      begin
        oc_cnt_d = '0;
        ol_cnt_d = '0;
        if (oc_act && oc_cnt_q != `LDF_OCP_CNT_W'(`LDF_OCP_CYC))
          oc_cnt_d = oc_cnt_q + `LDF_OCP_CNT_W'(1);
        else if (oc_act)
          oc_cnt_d = oc_cnt_q;
        if (ol_act && ol_cnt_q != `LDF_OL_CNT_W'(`LDF_OL_CYC))
          ol_cnt_d = ol_cnt_q + `LDF_OL_CNT_W'(1);
        else if (ol_act)
          ol_cnt_d = ol_cnt_q;
      end
      always_ff @(posedge mclk_in)
      begin
        if (!nrst_in || lrst)
        begin
          oc_cnt_q <= '0;
          ol_cnt_q <= '0;
        end
        else
        begin
          oc_cnt_q <= oc_cnt_d;
          ol_cnt_q <= ol_cnt_d;
        end
      end
      assign oc_set[gc] = oc_act &&
        oc_cnt_q == `LDF_OCP_CNT_W'(`LDF_OCP_CYC - 1);
      assign ol_set[gc] = ol_act &&
        ol_cnt_q == `LDF_OL_CNT_W'(`LDF_OL_CYC - 1);
    end
  endgenerate

  // Set wins over any clear in the same cycle
  logic [7:0] oc_clr;
  logic [7:0] ol_clr;
  always_comb
  begin
    oc_clr = {8{frst}} | ({8{commit}} & ~data_d);
    ol_clr = {8{frst}} | ({8{commit}} & data_d);
    fault_d.overcurrent_flag = oc_set | (fault_q.overcurrent_flag & ~oc_clr);
    fault_d.open_load_bits = OPEN_LOAD_DETECT ?
      (ol_set | (fault_q.open_load_bits & ~ol_clr)) : 8'h00;
  end

  // Outputs
  logic [7:0] chan_d;
  logic alert_oe_d;
  always_comb
  begin
    // Overcurrent channel stays off until its flag is cleared
    chan_d = data_d & ~fault_d.overcurrent_flag & {8{~tsd_s}};
    alert_oe_d = (|fault_d) | tsd_s;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in || lrst)
    begin
      sclk_prev_q <= 1'b0;
      // Idle latch level, so leaving reset is no false commit
      latch_prev_q <= 1'b1;
      sr_q <= `LDF_SHIFT_RST;
      dout_q <= 1'b0;
      wr_ctrl_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      data_q <= `LDF_DATA_RST;
      ctrl_q <= `LDF_CTRL_RST;
      pwm_q <= 1'b0;
      fault_q <= `LDF_FAULT_RST;
      channel_on_out <= 8'h00;
      fault_alert_n_oe_out <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_f;
      latch_prev_q <= latch_f;
      sr_q <= sr_d;
      dout_q <= dout_d;
      wr_ctrl_pend_q <= wr_ctrl_pend_d;
      rd_pend_q <= rd_pend_d;
      data_q <= data_d;
      ctrl_q <= ctrl_d;
      pwm_q <= pwm_d;
      fault_q <= fault_d;
      channel_on_out <= chan_d;
      fault_alert_n_oe_out <= alert_oe_d;
    end
  end

  // Open-drain alert only ever pulls low; line level comes from the chain
  always_ff @(posedge mclk_in)
  begin
    fault_alert_n_out <= 1'b0;
  end

  assign serial_data_out = dout_q;
  assign ctrl_reg_out = ctrl_q;
  assign pwm_start_out = pwm_q;

endmodule // ldf_core

// *** ldf_core_assertions.sv ***
/* Checker for the fault core: alert, shutdown, trip and command timing.
   Assumes it is bound to ldf_core and sees only its ports. */
`timescale 1ns/1ps
module ldf_core_assertions (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic latch_in,
  input wire logic chip_reset_n_in,
  input wire logic [7:0] overcurrent_in,
  input wire logic [7:0] open_load_sense_in,
  input wire logic thermal_shutdown_in,
  input wire logic supply_undervoltage_lockout_in,
  input wire ldf_pkg::ldf_cmd_t special_cmd_in,
  input wire logic fault_alert_n_out,
  input wire logic fault_alert_n_oe_out,
  input wire logic [7:0] channel_on_out,
  input wire logic pwm_start_out
);
  logic [8:0] oc_d, oc_q;
  logic [3:0] qt_d, qt_q;
  always_comb
  begin
    oc_d = (overcurrent_in[0] && channel_on_out[0]) ? oc_q + 9'h001 : 9'h000;
    qt_d = (qt_q == 4'hF) ? qt_q : qt_q + 4'h1;
    if (latch_in || thermal_shutdown_in)
      qt_d = 4'h0;
  end
  always_ff @(posedge mclk_in)
  begin
    oc_q <= nrst_in ? oc_d : 9'h000;
    qt_q <= nrst_in ? qt_d : 4'h0;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_alert_value: assert property (fault_alert_n_out == 1'b0)
    else $error("alert pin value not low");
  a_tsd_off: assert property (thermal_shutdown_in [*7] |->
    channel_on_out == 8'h00 && fault_alert_n_oe_out)
    else $error("outputs live during overtemperature");
  a_supply_undervoltage_lockout_quiet: assert property (
    supply_undervoltage_lockout_in [*7] |->
    !fault_alert_n_oe_out && channel_on_out == 8'h00)
    else $error("undervoltage left outputs or alert on");
  a_pwm_pulse: assert property (
    (chip_reset_n_in && !supply_undervoltage_lockout_in) [*8] ##0
    (special_cmd_in.valid && special_cmd_in.code ==
    ldf_pkg::LDF_CMD_PWM_START) |=> pwm_start_out)
    else $error("start pulse missing");
  a_pwm_cause: assert property (pwm_start_out |->
    $past(special_cmd_in) == {1'b1, ldf_pkg::LDF_CMD_PWM_START})
    else $error("start pulse without command");
  a_frst_clear: assert property (
    (!thermal_shutdown_in && overcurrent_in == 8'h00 &&
    open_load_sense_in == 8'h00) [*4] ##0 (special_cmd_in ==
    {1'b1, ldf_pkg::LDF_CMD_FAULT_RST}) |-> ##2 !fault_alert_n_oe_out)
    else $error("alert held after fault reset");
  a_ocp_trip: assert property (oc_q != 9'h136)
    else $error("channel stayed on through overcurrent");
  a_on_latch: assert property (qt_q == 4'hF |->
    (channel_on_out & ~$past(channel_on_out)) == 8'h00)
    else $error("channel turned on without latch");
endmodule // ldf_core_assertions

// *** ldf_core_tb_top.sv ***
/* Bench for the fault core: host frames, fault stimulus, commands.
   Assumes ldf_host as link partner and binds the checker. */
`timescale 1ns/1ps
module ldf_core_tb_top;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sclk, latch, sdat, rst_n, sdo, alert, oe, pwm;
  logic oe_b;
  logic [7:0] oc = 8'h00;
  logic [7:0] ol = 8'h00;
  logic thermal_shutdown = 1'b0;
  logic uv = 1'b0;
  logic [7:0] on, ctrl;
  ldf_pkg::ldf_cmd_t cmd = 4'h0;
  logic [15:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  initial
    forever #5 mclk_in = ~mclk_in;
  ldf_host i_host (.sclk_out(sclk), .latch_out(latch), .sdat_out(sdat),
    .rst_n_out(rst_n), .sdat_in(sdo));
  ldf_core i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .sclk_in(sclk),
    .latch_in(latch), .serial_data_in(sdat), .chip_reset_n_in(rst_n),
    .overcurrent_in(oc), .open_load_sense_in(ol),
    .thermal_shutdown_in(thermal_shutdown), .supply_undervoltage_lockout_in(uv),
    .special_cmd_in(cmd), .serial_data_out(sdo),
    .fault_alert_n_out(alert), .fault_alert_n_oe_out(oe),
    .channel_on_out(on), .ctrl_reg_out(ctrl), .pwm_start_out(pwm));
  // Variant without open-load sensing, same stimulus
  ldf_core #(.OPEN_LOAD_DETECT(1'b0)) i_dut_nol (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .sclk_in(sclk), .latch_in(latch),
    .serial_data_in(sdat), .chip_reset_n_in(rst_n), .overcurrent_in(oc),
    .open_load_sense_in(ol), .thermal_shutdown_in(thermal_shutdown),
    .supply_undervoltage_lockout_in(uv), .special_cmd_in(cmd),
    .serial_data_out(), .fault_alert_n_out(),
    .fault_alert_n_oe_out(oe_b), .channel_on_out(), .ctrl_reg_out(),
    .pwm_start_out());
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got,
    input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic wait_oe(input logic v, input int n);
    for (int k = 0; k < n && oe !== v; k++)
      cyc(1);
    chk("alert_oe", 16'(oe), 16'(v));
    if (oe !== v)
      tally_and_finish();
  endtask
  task automatic pulse(input ldf_pkg::ldf_cmd_code_t c);
    cmd = {1'b1, c};
    cyc(1);
    cmd = 4'h0;
  endtask
  task automatic frame(input logic [15:0] w);
    i_host.xfer(w, rd);
    cyc(1);
  endtask
  initial
  begin
    cyc(16);
    nrst_in = 1'b1;
    cyc(10);
    frame(16'h00A5);
    chk("on", 16'(on), 16'h00A5);
    oc = 8'h01;
    cyc(280);
    chk("ocp_early", 16'(on), 16'h00A5);
    cyc(40);
    chk("ocp_off", 16'(on), 16'h00A4);
    wait_oe(1'b1, 4);
    frame(16'h00A5);
    chk("fault_rd", rd, 16'h0001);
    oc = 8'h00;
    frame(16'h00A4);
    wait_oe(1'b0, 4);
    $display("overcurrent test done");
    ol = 8'h02;
    cyc(1650);
    wait_oe(1'b0, 1);
    wait_oe(1'b1, 80);
    chk("nol_oe", 16'(oe_b), 16'h0000);
    frame(16'h00A6);
    chk("ol_rd", rd, 16'h0200);
    wait_oe(1'b0, 4);
    frame(16'h00A4);
    wait_oe(1'b1, 1800);
    ol = 8'h00;
    cyc(4);
    pulse(ldf_pkg::LDF_CMD_FAULT_RST);
    wait_oe(1'b0, 3);
    $display("open load test done");
    i_host.glitch();
    cyc(20);
    chk("glitch", 16'(on), 16'h00A4);
    thermal_shutdown = 1'b1;
    cyc(8);
    chk("tsd_on", 16'(on), 16'h0000);
    wait_oe(1'b1, 1);
    thermal_shutdown = 1'b0;
    cyc(8);
    chk("tsd_back", 16'(on), 16'h00A4);
    wait_oe(1'b0, 1);
    $display("filter and thermal tests done");
    pulse(ldf_pkg::LDF_CMD_PWM_START);
    chk("pwm", 16'(pwm), 16'h0001);
    cyc(1);
    pulse(ldf_pkg::LDF_CMD_WR_CTRL);
    frame(16'h003C);
    chk("ctrl", 16'(ctrl), 16'h003C);
    chk("data_kept", 16'(on), 16'h00A4);
    pulse(ldf_pkg::LDF_CMD_RD_CTRL);
    cyc(1);
    chk("rd_ctrl", 16'(sdo), 16'h0000);
    frame(16'h00A4);
    chk("rd_ctrl_frame", rd, 16'h3C00);
    pulse(ldf_pkg::LDF_CMD_RD_DATA);
    cyc(1);
    chk("rd_data", 16'(sdo), 16'h0001);
    frame(16'h00A4);
    chk("rd_data_frame", rd, 16'hA400);
    $display("command test done");
    oc = 8'h01;
    frame(16'h00A5);
    wait_oe(1'b1, 340);
    uv = 1'b1;
    cyc(8);
    wait_oe(1'b0, 1);
    oc = 8'h00;
    uv = 1'b0;
    cyc(8);
    chk("uv_data", 16'(on), 16'h0000);
    chk("uv_ctrl", 16'(ctrl), 16'h0000);
    $display("undervoltage test done");
    tally_and_finish();
  end
endmodule // ldf_core_tb_top
bind ldf_core ldf_core_assertions i_chk (.mclk_in(mclk_in),
  .nrst_in(nrst_in), .latch_in(latch_in),
  .chip_reset_n_in(chip_reset_n_in), .overcurrent_in(overcurrent_in),
  .open_load_sense_in(open_load_sense_in),
  .thermal_shutdown_in(thermal_shutdown_in),
  .supply_undervoltage_lockout_in(supply_undervoltage_lockout_in),
  .special_cmd_in(special_cmd_in), .fault_alert_n_out(fault_alert_n_out),
  .fault_alert_n_oe_out(fault_alert_n_oe_out),
  .channel_on_out(channel_on_out), .pwm_start_out(pwm_start_out));

// *** ldf_filt.sv ***
/*
 * Two-flop synchroniser plus digital glitch filter for one pin.
 * Assumes the pin is asynchronous to mclk_in.
 */
`timescale 1ns/1ps
`include "ldf_params.svh"

module ldf_filt (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic raw_in,
  output logic clean_out
);

  logic s1_q;
  logic s2_q;
  logic clean_q;
  logic clean_d;
  logic [`LDF_FILT_CNT_W-1:0] cnt_q;
  logic [`LDF_FILT_CNT_W-1:0] cnt_d;

  // Level must stay different for the whole window before it is taken
  always_comb
  begin
    clean_d = clean_q;
    cnt_d = '0;
    if (s2_q != clean_q)
    begin
      if (cnt_q == `LDF_FILT_CNT_W'(`LDF_FILT_CYC - 1))
        clean_d = s2_q;
      else
        cnt_d = cnt_q + `LDF_FILT_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      clean_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      clean_q <= clean_d;
      cnt_q <= cnt_d;
    end
  end

  assign clean_out = clean_q;

endmodule // ldf_filt

// *** ldf_host.sv ***
/* Host end of the serial link: 16-bit frames MSB first, latch glitch.
   Assumes the core filters and synchronises these pins. */
`timescale 1ns/1ps
module ldf_host (
  output logic sclk_out,
  output logic latch_out,
  output logic sdat_out,
  output logic rst_n_out,
  input wire logic sdat_in
);
  initial
  begin
    sclk_out = 1'b0;
    latch_out = 1'b1;
    sdat_out = 1'b0;
    rst_n_out = 1'b1;
  end
  // Sample late in the high phase: the answer lags the fall by ~60 ns
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    latch_out = 1'b0;
    #250;
    for (int i = 15; i >= 0; i--)
    begin
      sdat_out = w[i];
      #62.5 sclk_out = 1'b1;
      #62.5 r[i] = sdat_in;
      sclk_out = 1'b0;
    end
    #125 sdat_out = ~w[0];
    latch_out = 1'b1;
    #250;
  endtask
  task automatic glitch();
    latch_out = 1'b0;
    #20 latch_out = 1'b1;
  endtask
endmodule // ldf_host

// *** ldf_params.svh ***
/*
 * Timing counts, widths and reset values of the low-side driver fault logic.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef LDF_PARAMS_SVH
`define LDF_PARAMS_SVH

`define LDF_CLK_NS 10
`define LDF_CHANNELS 8
// Overcurrent deglitch, nominal figure, least time rounded up
`define LDF_OCP_DEGLITCH_NS 3000
`define LDF_OCP_CYC ((`LDF_OCP_DEGLITCH_NS + `LDF_CLK_NS - 1) / `LDF_CLK_NS)
`define LDF_OCP_CNT_W 9
// Open-load deglitch, nominal figure
`define LDF_OL_DEGLITCH_NS 17000
`define LDF_OL_CYC ((`LDF_OL_DEGLITCH_NS + `LDF_CLK_NS - 1) / `LDF_CLK_NS)
`define LDF_OL_CNT_W 11
// Input glitch filter: shorter pulses are dropped
`define LDF_FILT_NS 30
`define LDF_FILT_CYC ((`LDF_FILT_NS + `LDF_CLK_NS - 1) / `LDF_CLK_NS)
`define LDF_FILT_CNT_W 3
`define LDF_DATA_RST 8'h00
`define LDF_CTRL_RST 8'h00
`define LDF_SHIFT_RST 16'h0000
`define LDF_FAULT_RST 16'h0000

`endif

// *** ldf_pkg.sv ***
/*
 * Types of the low-side driver fault logic: fault bank layout and the
 * decoded special command. Assumes ldf_params.svh for the constants.
 */
package ldf_pkg;

  typedef enum logic [2:0] {
    LDF_CMD_WR_CTRL,
    LDF_CMD_RD_CTRL,
    LDF_CMD_RD_DATA,
    LDF_CMD_FAULT_RST,
    LDF_CMD_PWM_START
  } ldf_cmd_code_t;

  typedef struct packed {
    logic valid;
    ldf_cmd_code_t code;
  } ldf_cmd_t;

  // Shifted out open-load byte first, then overcurrent byte
  typedef struct packed {
    logic [7:0] open_load_bits;
    logic [7:0] overcurrent_flag;
  } ldf_fault_t;

endpackage
